// ### design/vpw_fifo.sv
`timescale 1ns/1ps
`default_nettype none

module vpw_fifo #(
	parameter int WIDTH = 9,
	parameter int DEPTH = 8
) (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic [WIDTH-1:0] in_data_in,
	input wire logic in_valid_in,
	output logic in_ready_out,
	output logic [WIDTH-1:0] out_data_out,
	output logic out_valid_out,
	input wire logic out_ready_in
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0] wr_ptr;
	logic [AW:0] rd_ptr;
	logic full;
	logic empty;

	assign empty = (wr_ptr == rd_ptr);
	assign full = (wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
	assign in_ready_out = !full;
	assign out_valid_out = !empty;
	assign out_data_out = mem[rd_ptr[AW-1:0]];

	always_ff @(posedge clk_in)
	begin
		if (in_valid_in && !full)
			mem[wr_ptr[AW-1:0]] <= in_data_in;
	end

	always_ff @(posedge clk_in)
	begin
		if (rst_in)
		begin
			wr_ptr <= '0;
			rd_ptr <= '0;
		end
		else
		begin
			if (in_valid_in && !full)
				wr_ptr <= wr_ptr + 1'b1;
			if (out_ready_in && !empty)
				rd_ptr <= rd_ptr + 1'b1;
		end
	end

endmodule

`default_nettype wire

// ### design/vpw_symbol_timing.sv
`timescale 1ns/1ps
`default_nettype none

module vpw_symbol_timing
	import vpw_timing_pkg::*;
(
	input wire logic sys_clk_in,
	input wire logic sys_rst_in,
	input wire logic link_freq_sel_in,
	input wire logic [7:0] tx_data_in,
	input wire logic tx_last_in,
	input wire logic tx_valid_in,
	output logic tx_ready_out,
	output logic bus_tx_pin_out,
	output logic tx_eod_out,
	output logic tx_eof_out,
	output logic tx_underrun_out,
	input wire logic bus_rx_pin_in,
	output logic [7:0] rx_byte_out,
	output logic rx_byte_valid_out,
	output logic rx_sof_out,
	output logic rx_eod_out,
	output logic rx_eof_out,
	output logic rx_break_out,
	output logic rx_error_out
);

	// =====================================================
	// link clock tick
	phase_t phase;
	logic tick;
	logic [PHASE_W:0] phase_sum;

	assign phase_sum = {1'b0, phase} + {1'b0, (link_freq_sel_in ? PHASE_INC_FAST : PHASE_INC_SLOW)};

	always_ff @(posedge sys_clk_in)
	begin
		if (sys_rst_in)
		begin
			phase <= PHASE_RESET;
			tick <= 1'b0;
		end
		else
		begin
			phase <= phase_sum[PHASE_W-1:0];
			tick <= phase_sum[PHASE_W];
		end
	end

	len_t lim_short, lim_long, lim_sof, lim_eod, lim_eof, lim_ifs;
	len_t lim_bit_min, lim_mid, lim_sof_min, lim_eof_min, lim_break;

	always_comb
	begin
		lim_short = link_freq_sel_in ? TX_SHORT_FAST : TX_SHORT_SLOW;
		lim_long = link_freq_sel_in ? TX_LONG_FAST : TX_LONG_SLOW;
		lim_sof = link_freq_sel_in ? TX_SOF_FAST : TX_SOF_SLOW;
		lim_eod = link_freq_sel_in ? TX_EOD_FAST : TX_EOD_SLOW;
		lim_eof = link_freq_sel_in ? TX_EOF_FAST : TX_EOF_SLOW;
		lim_ifs = link_freq_sel_in ? TX_IFS_FAST : TX_IFS_SLOW;
		lim_bit_min = link_freq_sel_in ? RX_BIT_MIN_FAST : RX_BIT_MIN_SLOW;
		lim_mid = link_freq_sel_in ? RX_MID_FAST : RX_MID_SLOW;
		lim_sof_min = link_freq_sel_in ? RX_SOF_MIN_FAST : RX_SOF_MIN_SLOW;
		lim_eof_min = link_freq_sel_in ? RX_EOF_MIN_FAST : RX_EOF_MIN_SLOW;
		lim_break = link_freq_sel_in ? RX_BREAK_FAST : RX_BREAK_SLOW;
	end

	// =====================================================
	// transmit queue
	logic [FIFO_WIDTH-1:0] q_data;
	logic q_valid;
	logic q_pop;

	vpw_fifo #(.WIDTH(FIFO_WIDTH), .DEPTH(FIFO_DEPTH)) tx_queue (
		.clk_in(sys_clk_in),
		.rst_in(sys_rst_in),
		.in_data_in({tx_last_in, tx_data_in}),
		.in_valid_in(tx_valid_in),
		.in_ready_out(tx_ready_out),
		.out_data_out(q_data),
		.out_valid_out(q_valid),
		.out_ready_in(q_pop)
	);

	// =====================================================
	// transmitter
	tx_state_t tx_state;
	len_t sym_cnt;
	len_t gap_cnt;
	len_t sym_len;
	logic [7:0] tx_shift;
	logic [2:0] bit_idx;
	logic tx_last;
	logic eof_pend;
	logic sym_end;

	// active bits: one is short; passive bits: zero is short
	assign sym_len = (tx_state == TX_SOF) ? lim_sof :
		((tx_shift[7] ^ bit_idx[0]) ? lim_long : lim_short);
	assign sym_end = tick && (sym_cnt + 1'b1 == sym_len);
	assign q_pop = sym_end && q_valid && ((tx_state == TX_SOF) || (bit_idx == BIT_LAST && !tx_last));

	always_ff @(posedge sys_clk_in)
	begin
		if (sys_rst_in)
		begin
			tx_state <= TX_IDLE;
			bus_tx_pin_out <= 1'b0;
			sym_cnt <= LEN_RESET;
			tx_shift <= 8'h00;
			bit_idx <= 3'h0;
			tx_last <= 1'b0;
			tx_underrun_out <= 1'b0;
		end
		else
		begin
			tx_underrun_out <= 1'b0;
			if (tx_state != TX_IDLE && tick)
				sym_cnt <= sym_cnt + 1'b1;
			unique case (tx_state)
				TX_IDLE:
				begin
					if (tick && q_valid && !eof_pend && gap_cnt + 1'b1 >= lim_ifs)
					begin
						tx_state <= TX_SOF;
						bus_tx_pin_out <= 1'b1;
						sym_cnt <= LEN_RESET;
					end
				end
				TX_SOF, TX_BITS:
				begin
					if (sym_end)
					begin
						sym_cnt <= LEN_RESET;
						if (tx_state == TX_BITS && bit_idx != BIT_LAST)
						begin
							bit_idx <= bit_idx + 1'b1;
							tx_shift <= {tx_shift[6:0], 1'b0};
							bus_tx_pin_out <= !bit_idx[0];
						end
						else if ((tx_state == TX_SOF || !tx_last) && q_valid)
						begin
							tx_state <= TX_BITS;
							tx_shift <= q_data[7:0];
							tx_last <= q_data[8];
							bit_idx <= 3'h0;
							bus_tx_pin_out <= 1'b0;
						end
						else
						begin
							tx_state <= TX_IDLE;
							bus_tx_pin_out <= 1'b0;
							tx_underrun_out <= !(tx_state == TX_BITS && tx_last);
						end
					end
				end
				default:
				begin
					tx_state <= TX_IDLE;
					bus_tx_pin_out <= 1'b0;
				end
			endcase
		end
	end

	// passive time since the last active symbol ended
	always_ff @(posedge sys_clk_in)
	begin
		if (sys_rst_in)
		begin
			gap_cnt <= LEN_RESET;
			eof_pend <= 1'b0;
			tx_eod_out <= 1'b0;
			tx_eof_out <= 1'b0;
		end
		else
		begin
			tx_eod_out <= eof_pend && tick && (gap_cnt + 1'b1 == lim_eod);
			tx_eof_out <= eof_pend && tick && (gap_cnt + 1'b1 == lim_eof);
			if (bus_tx_pin_out)
			begin
				gap_cnt <= LEN_RESET;
				eof_pend <= 1'b1;
			end
			else if (tick && gap_cnt != lim_ifs)
				gap_cnt <= gap_cnt + 1'b1;
			if (!bus_tx_pin_out && tick && (gap_cnt + 1'b1 == lim_eof))
				eof_pend <= 1'b0;
		end
	end

	// =====================================================
	// receiver
	logic rx_s1, rx_s2, rx_s3;
	logic rx_level;
	logic rx_edge;
	len_t rx_len;
	logic rx_bit_ev;
	logic rx_bit_val;
	logic rx_in_frame;
	logic [2:0] rx_bit_cnt;
	logic [7:0] rx_shift;

	always_ff @(posedge sys_clk_in)
	begin
		if (sys_rst_in)
		begin
			rx_s1 <= 1'b0;
			rx_s2 <= 1'b0;
			rx_s3 <= 1'b0;
			rx_level <= 1'b0;
		end
		else
		begin
			rx_s1 <= bus_rx_pin_in;
			rx_s2 <= rx_s1;
			rx_s3 <= rx_s2;
			if (rx_s2 == rx_s3)
				rx_level <= rx_s3;
		end
	end

	assign rx_edge = (rx_s2 == rx_s3) && (rx_s3 != rx_level);

	// pulse length in link ticks, saturating
	always_ff @(posedge sys_clk_in)
	begin
		if (sys_rst_in)
			rx_len <= LEN_RESET;
		else if (rx_edge)
			rx_len <= LEN_RESET;
		else if (tick && rx_len != '1)
			rx_len <= rx_len + 1'b1;
	end

	always_ff @(posedge sys_clk_in)
	begin
		if (sys_rst_in)
		begin
			rx_bit_ev <= 1'b0;
			rx_bit_val <= 1'b0;
			rx_sof_out <= 1'b0;
			rx_eod_out <= 1'b0;
			rx_eof_out <= 1'b0;
			rx_break_out <= 1'b0;
			rx_error_out <= 1'b0;
		end
		else
		begin
			rx_bit_ev <= 1'b0;
			rx_sof_out <= 1'b0;
			rx_eod_out <= 1'b0;
			rx_eof_out <= 1'b0;
			rx_break_out <= 1'b0;
			rx_error_out <= 1'b0;
			if (rx_edge)
			begin
				if (rx_len < lim_bit_min)
					rx_error_out <= 1'b1;
				else if (rx_len < lim_mid)
				begin
					rx_bit_ev <= 1'b1;
					rx_bit_val <= rx_level;
				end
				else if (rx_len < lim_sof_min)
				begin
					rx_bit_ev <= 1'b1;
					rx_bit_val <= !rx_level;
				end
				else if (rx_len < lim_eof_min)
				begin
					rx_sof_out <= rx_level;
					rx_eod_out <= !rx_level;
				end
				else if (rx_level && rx_len < lim_break)
					rx_error_out <= 1'b1;
			end
			else if (tick && rx_len + 1'b1 == lim_eof_min && !rx_level)
				rx_eof_out <= 1'b1;
			else if (tick && rx_len + 1'b1 == lim_break && rx_level)
				rx_break_out <= 1'b1;
		end
	end

	// frame tracking and byte assembly
	always_ff @(posedge sys_clk_in)
	begin
		if (sys_rst_in)
		begin
			rx_in_frame <= 1'b0;
			rx_bit_cnt <= 3'h0;
			rx_shift <= 8'h00;
			rx_byte_out <= 8'h00;
			rx_byte_valid_out <= 1'b0;
		end
		else
		begin
			rx_byte_valid_out <= 1'b0;
			if (rx_sof_out)
			begin
				rx_in_frame <= 1'b1;
				rx_bit_cnt <= 3'h0;
			end
			else if (rx_error_out || rx_break_out || rx_eof_out)
				rx_in_frame <= 1'b0;
			else if (rx_bit_ev && rx_in_frame)
			begin
				rx_shift <= {rx_shift[6:0], rx_bit_val};
				rx_bit_cnt <= rx_bit_cnt + 1'b1;
				if (rx_bit_cnt == BIT_LAST)
				begin
					rx_byte_out <= {rx_shift[6:0], rx_bit_val};
					rx_byte_valid_out <= 1'b1;
				end
			end
		end
	end

	// =====================================================
	// checks
	len_t tx_obs_len;
	logic tx_prev;

	always_ff @(posedge sys_clk_in)
	begin
		if (sys_rst_in)
		begin
			tx_obs_len <= LEN_RESET;
			tx_prev <= 1'b0;
		end
		else
		begin
			tx_prev <= bus_tx_pin_out;
			if (tx_prev != bus_tx_pin_out)
				tx_obs_len <= LEN_RESET;
			else if (tick && tx_obs_len != '1)
				tx_obs_len <= tx_obs_len + 1'b1;
		end
	end

	sequence s_frame_start;
		$rose(bus_tx_pin_out) ##0 (tx_state == TX_SOF);
	endsequence

	sequence s_rx_active_end;
		$past(rx_level) ##0 !rx_level;
	endsequence

	a_tick_spacing: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in) tick |=> !tick)
		else $error("link ticks back to back");
	a_tick_due: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in) tick |-> ##[1:101] tick)
		else $error("link tick missing");
	a_tx_active_len: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
		$fell(bus_tx_pin_out) |-> (tx_obs_len == lim_short || tx_obs_len == lim_long || tx_obs_len == lim_sof))
		else $error("active symbol length wrong");
	a_tx_passive_len: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
		$rose(bus_tx_pin_out) |-> (tx_obs_len == lim_short || tx_obs_len == lim_long || tx_obs_len >= lim_ifs))
		else $error("passive symbol length wrong");
	a_tx_ifs_gap: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
		s_frame_start |-> $past(tx_obs_len) >= lim_ifs - 1'b1)
		else $error("frame started before separator");
	a_tx_eod_time: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
		tx_eod_out |-> !bus_tx_pin_out && tx_obs_len == lim_eod)
		else $error("end of data at wrong time");
	a_tx_eof_time: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
		tx_eof_out |-> !bus_tx_pin_out && tx_obs_len == lim_eof)
		else $error("end of frame at wrong time");
	a_rx_bit_decode: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
		rx_bit_ev |-> $past(rx_len) >= lim_bit_min && $past(rx_len) < lim_sof_min
			&& rx_bit_val == ($past(rx_level) ^ ($past(rx_len) >= lim_mid)))
		else $error("bit decoded from wrong pulse");
	a_rx_sof_window: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
		rx_sof_out |-> s_rx_active_end and ($past(rx_len) >= lim_sof_min && $past(rx_len) < lim_eof_min))
		else $error("start of frame outside window");
	a_rx_eof_time: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
		rx_eof_out |-> !rx_level && rx_len == lim_eof_min)
		else $error("end of frame at wrong time");
	a_rx_break_time: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
		rx_break_out |-> rx_level && rx_len == lim_break)
		else $error("break at wrong time");
	a_rx_error_drop: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
		rx_error_out |=> !rx_in_frame && !rx_byte_valid_out)
		else $error("frame kept after error");
	a_rx_sync_agree: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
		(rx_level != $past(rx_level)) |-> $past(rx_s2) == $past(rx_s3))
		else $error("receive level changed unsettled");

endmodule

`default_nettype wire

// ### shared/vpw_timing_pkg.sv
package vpw_timing_pkg;

	// =====================================================
	// link clock tick generation
	localparam int SYS_CLK_HZ = 100_000_000;
	localparam int LINK_SLOW_HZ = 1_000_000;
	localparam int LINK_FAST_HZ = 1_048_576;
	localparam int US_PER_S = 1_000_000;
	localparam int PHASE_W = 24;
	typedef logic [PHASE_W-1:0] phase_t;
	localparam phase_t PHASE_INC_SLOW = phase_t'((longint'(LINK_SLOW_HZ) << PHASE_W) / SYS_CLK_HZ);
	localparam phase_t PHASE_INC_FAST = phase_t'((longint'(LINK_FAST_HZ) << PHASE_W) / SYS_CLK_HZ);
	localparam phase_t PHASE_RESET = 24'h00_0000;
	// longest gap between two ticks, in system clock cycles
	localparam int TICK_GAP_MAX_CYC = SYS_CLK_HZ / LINK_SLOW_HZ + 1;

	// =====================================================
	// symbol lengths in microseconds
	localparam int LEN_W = 10;
	typedef logic [LEN_W-1:0] len_t;
	localparam len_t LEN_RESET = 10'h000;
	localparam int TX_SHORT_US = 64;
	localparam int TX_LONG_US = 128;
	localparam int TX_SOF_US = 200;
	localparam int TX_EOD_US = 200;
	localparam int TX_EOF_US = 280;
	localparam int TX_IFS_US = 300;
	localparam int RX_BIT_MIN_US = 34;
	localparam int RX_MID_US = 96;
	localparam int RX_SOF_MIN_US = 163;
	localparam int RX_EOF_MIN_US = 239;
	localparam int RX_EOF_MAX_US = 320;
	localparam int RX_BREAK_US = 280;

	// =====================================================
	// same lengths in link clock ticks, for each link rate
	localparam len_t TX_SHORT_SLOW = len_t'(TX_SHORT_US * LINK_SLOW_HZ / US_PER_S);
	localparam len_t TX_SHORT_FAST = len_t'((TX_SHORT_US * LINK_FAST_HZ + US_PER_S / 2) / US_PER_S);
	localparam len_t TX_LONG_SLOW = len_t'(TX_LONG_US * LINK_SLOW_HZ / US_PER_S);
	localparam len_t TX_LONG_FAST = len_t'((TX_LONG_US * LINK_FAST_HZ + US_PER_S / 2) / US_PER_S);
	localparam len_t TX_SOF_SLOW = len_t'(TX_SOF_US * LINK_SLOW_HZ / US_PER_S);
	localparam len_t TX_SOF_FAST = len_t'((TX_SOF_US * LINK_FAST_HZ + US_PER_S / 2) / US_PER_S);
	localparam len_t TX_EOD_SLOW = len_t'(TX_EOD_US * LINK_SLOW_HZ / US_PER_S);
	localparam len_t TX_EOD_FAST = len_t'((TX_EOD_US * LINK_FAST_HZ + US_PER_S / 2) / US_PER_S);
	localparam len_t TX_EOF_SLOW = len_t'(TX_EOF_US * LINK_SLOW_HZ / US_PER_S);
	localparam len_t TX_EOF_FAST = len_t'((TX_EOF_US * LINK_FAST_HZ + US_PER_S / 2) / US_PER_S);
	localparam len_t TX_IFS_SLOW = len_t'(TX_IFS_US * LINK_SLOW_HZ / US_PER_S);
	localparam len_t TX_IFS_FAST = len_t'((TX_IFS_US * LINK_FAST_HZ + US_PER_S / 2) / US_PER_S);
	localparam len_t RX_BIT_MIN_SLOW = len_t'(RX_BIT_MIN_US * LINK_SLOW_HZ / US_PER_S);
	localparam len_t RX_BIT_MIN_FAST = len_t'((RX_BIT_MIN_US * LINK_FAST_HZ + US_PER_S / 2) / US_PER_S);
	localparam len_t RX_MID_SLOW = len_t'(RX_MID_US * LINK_SLOW_HZ / US_PER_S);
	localparam len_t RX_MID_FAST = len_t'((RX_MID_US * LINK_FAST_HZ + US_PER_S / 2) / US_PER_S);
	localparam len_t RX_SOF_MIN_SLOW = len_t'(RX_SOF_MIN_US * LINK_SLOW_HZ / US_PER_S);
	localparam len_t RX_SOF_MIN_FAST = len_t'((RX_SOF_MIN_US * LINK_FAST_HZ + US_PER_S / 2) / US_PER_S);
	localparam len_t RX_EOF_MIN_SLOW = len_t'(RX_EOF_MIN_US * LINK_SLOW_HZ / US_PER_S);
	localparam len_t RX_EOF_MIN_FAST = len_t'((RX_EOF_MIN_US * LINK_FAST_HZ + US_PER_S / 2) / US_PER_S);
	localparam len_t RX_BREAK_SLOW = len_t'(RX_BREAK_US * LINK_SLOW_HZ / US_PER_S);
	localparam len_t RX_BREAK_FAST = len_t'((RX_BREAK_US * LINK_FAST_HZ + US_PER_S / 2) / US_PER_S);

	// =====================================================
	// transmit queue and transmitter states
	localparam int FIFO_WIDTH = 9;
	localparam int FIFO_DEPTH = 8;
	localparam logic [2:0] BIT_LAST = 3'h7;
	typedef enum logic [1:0]
	{
		TX_IDLE = 2'h0,
		TX_SOF = 2'h1,
		TX_BITS = 2'h3
	} tx_state_t;

endpackage

// ### testbench/vpw_bus_node.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// other node on the shared bus, drives the receive pin
module vpw_bus_node
(
	input wire logic sys_clk_in,
	output logic bus_out
);
	initial bus_out = 1'b0;

	// hold one level for a length in microseconds
	task automatic hold(input logic level, input int us);
		bus_out = level;
		repeat (us * 100) @(negedge sys_clk_in);
	endtask

	// odd bits passive; short when bit equals level, lengths clear of window edges
	task automatic send_bit(input logic b, input int i);
		logic level;
		level = ~i[0];
		hold(level, (b == level) ? 38 + $urandom_range(54) : 100 + $urandom_range(50));
	endtask
endmodule
`default_nettype wire

// ### testbench/vpw_symbol_timing_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module vpw_symbol_timing_tb_top;
	import vpw_timing_pkg::*;
	localparam int LIMIT = 600000;
	logic sys_clk_in = 1'b0;
	logic sys_rst_in = 1'b1;
	logic fast = 1'b0;
	logic [7:0] tx_data = 8'h00;
	logic tx_last = 1'b0;
	logic tx_valid = 1'b0;
	logic tx_ready, tx_pin, tx_eod, tx_eof, tx_underrun, rx_pin;
	logic [7:0] rx_byte;
	logic rx_byte_valid, rx_sof, rx_eod, rx_eof, rx_break, rx_error;
	logic [5:0] flags;
	logic [8:0] got_q[$];
	logic [8:0] exp_q[$];
	int fails = 0;
	int samples_checked = 0;
	int cyc = 0;

	assign flags = {tx_pin, tx_underrun, tx_eof, tx_eod, rx_break, rx_eof};
	always #5 sys_clk_in = ~sys_clk_in;

	vpw_symbol_timing i_dut (.sys_clk_in(sys_clk_in), .sys_rst_in(sys_rst_in), .link_freq_sel_in(fast),
		.tx_data_in(tx_data), .tx_last_in(tx_last), .tx_valid_in(tx_valid), .tx_ready_out(tx_ready),
		.bus_tx_pin_out(tx_pin), .tx_eod_out(tx_eod), .tx_eof_out(tx_eof), .tx_underrun_out(tx_underrun),
		.bus_rx_pin_in(rx_pin), .rx_byte_out(rx_byte), .rx_byte_valid_out(rx_byte_valid),
		.rx_sof_out(rx_sof), .rx_eod_out(rx_eod), .rx_eof_out(rx_eof), .rx_break_out(rx_break),
		.rx_error_out(rx_error));
	vpw_bus_node i_node (.sys_clk_in(sys_clk_in), .bus_out(rx_pin));

	// ==========================================
	// receive event log and timeout; pulses are read at the falling edge, where they are settled
	always @(negedge sys_clk_in)
	begin
		if (!sys_rst_in)
		begin
			if (rx_sof) got_q.push_back(9'h001);
			if (rx_eod) got_q.push_back(9'h002);
			if (rx_eof) got_q.push_back(9'h003);
			if (rx_break) got_q.push_back(9'h004);
			if (rx_error) got_q.push_back(9'h005);
			if (rx_byte_valid) got_q.push_back({1'b1, rx_byte});
		end
	end

	always @(posedge sys_clk_in)
	begin
		cyc++;
		if (cyc == LIMIT)
		begin
			fails++;
			report_and_stop();
		end
	end

	// ==========================================
	// checking helpers
	task automatic report_and_stop();
		if (fails == 0 && samples_checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	task automatic compare_eq(input logic [8:0] got, input logic [8:0] exp, input string what);
		samples_checked++;
		if (got !== exp)
		begin
			fails++;
			$display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask

	task automatic compare_len(input int got, input int lo, input int hi, input string what);
		samples_checked++;
		if (got < lo || got > hi)
		begin
			fails++;
			$display("wrong value at %0t: %s got %0d expected %0d..%0d", $time, what, got, lo, hi);
		end
	endtask

	function automatic int pick(input int slow, input int quick);
		return fast ? quick : slow;
	endfunction

	// system cycles spanned by a number of link ticks
	function automatic int cycles(input int ticks);
		return int'((longint'(ticks) << PHASE_W) / (fast ? PHASE_INC_FAST : PHASE_INC_SLOW));
	endfunction

	task automatic count_until(input int idx, input logic val, output int n);
		n = 0;
		while (flags[idx] !== val && n < 60000)
		begin
			@(negedge sys_clk_in);
			n++;
		end
	endtask

	task automatic do_reset(input logic rate);
		@(negedge sys_clk_in);
		sys_rst_in = 1'b1;
		fast = rate;
		repeat (2) @(negedge sys_clk_in);
		compare_eq({tx_ready, tx_pin, tx_eod, tx_eof, tx_underrun, rx_byte_valid, rx_sof, rx_eod, rx_break},
			9'h100, "reset outputs");
		sys_rst_in = 1'b0;
		got_q.delete();
		exp_q.delete();
	endtask

	task automatic push_word(input logic [7:0] d, input logic last);
		tx_data = d;
		tx_last = last;
		tx_valid = 1'b1;
		while (tx_ready !== 1'b1) @(negedge sys_clk_in);
		@(negedge sys_clk_in);
	endtask

	// ==========================================
	// transmit wire walk for a frame of one or two bytes, first byte in the upper bits
	task automatic tx_check(input logic [15:0] d, input int nbits, input logic last);
		int n;
		int n2;
		int t;
		logic level;
		t = pick(TX_IFS_SLOW, TX_IFS_FAST);
		count_until(5, 1'b1, n);
		compare_len(n, cycles(t) - 2, cycles(t + 1) + 3, "idle gap");
		t = pick(TX_SOF_SLOW, TX_SOF_FAST);
		count_until(5, 1'b0, n);
		compare_len(n, cycles(t) - 2, cycles(t) + 2, "start length");
		for (int i = nbits - 1; i >= 0; i--)
		begin
			level = ~i[0];
			t = (d[i] == level) ? pick(TX_SHORT_SLOW, TX_SHORT_FAST) : pick(TX_LONG_SLOW, TX_LONG_FAST);
			count_until(5, ~level, n);
			compare_len(n, cycles(t) - 2, cycles(t) + 2, "bit length");
		end
		if (last)
		begin
			count_until(2, 1'b1, n);
			t = pick(TX_EOD_SLOW, TX_EOD_FAST);
			compare_len(n, cycles(t) - 2, cycles(t) + 3, "data end");
			count_until(3, 1'b1, n2);
			t = pick(TX_EOF_SLOW, TX_EOF_FAST);
			compare_len(n + n2, cycles(t) - 2, cycles(t) + 3, "frame end");
		end
		else
		begin
			count_until(4, 1'b1, n);
			compare_len(n, 0, 2, "underrun");
		end
	endtask

	// ==========================================
	// receive run: full frame with break, or cut short by a runt pulse
	task automatic rx_run(input logic broken);
		logic [7:0] b;
		int n;
		int t;
		b = 8'($urandom);
		i_node.hold(1'b0, broken ? 180 : 40);
		if (broken) exp_q.push_back(9'h002);
		i_node.hold(1'b1, 200);
		exp_q.push_back(9'h001);
		for (int i = 7; i > (broken ? 4 : -1); i--)
			i_node.send_bit(b[i], i);
		if (broken)
		begin
			i_node.hold(1'b1, 20);
			exp_q.push_back(9'h005);
		end
		else
		begin
			exp_q.push_back({1'b1, b});
			i_node.hold(1'b0, 180);
			exp_q.push_back(9'h002);
			t = pick(RX_BREAK_SLOW, RX_BREAK_FAST);
			fork
				i_node.hold(1'b1, 290);
				count_until(1, 1'b1, n);
			join
			compare_len(n, cycles(t - 1), cycles(t + 1) + 8, "break delay");
			exp_q.push_back(9'h004);
		end
		t = pick(RX_EOF_MIN_SLOW, RX_EOF_MIN_FAST);
		fork
			i_node.hold(1'b0, 250);
			count_until(0, 1'b1, n);
		join
		compare_len(n, cycles(t - 1), cycles(t + 1) + 8, "frame end delay");
		exp_q.push_back(9'h003);
	endtask

	task automatic check_rx();
		compare_len(got_q.size(), exp_q.size(), exp_q.size(), "event count");
		foreach (exp_q[i])
			if (i < got_q.size()) compare_eq(got_q[i], exp_q[i], "receive event");
	endtask

	// ==========================================
	// main sequence
	initial
	begin
		logic [15:0] d;
		void'($urandom(96));
		do_reset(1'b0);
		tx_valid = 1'b1;
		repeat (8)
		begin
			tx_data = 8'($urandom);
			@(negedge sys_clk_in);
		end
		repeat (3) @(negedge sys_clk_in);
		compare_eq({8'h00, tx_ready}, 9'h000, "queue full");
		tx_valid = 1'b0;
		do_reset(1'b0);
		d = 16'($urandom);
		fork
			begin
				push_word(d[15:8], 1'b0);
				push_word(d[7:0], 1'b1);
				tx_valid = 1'b0;
			end
			tx_check(d, 16, 1'b1);
			rx_run(1'b0);
		join
		check_rx();
		do_reset(1'b1);
		d = 16'($urandom);
		fork
			begin
				push_word(d[7:0], 1'b0);
				tx_valid = 1'b0;
			end
			tx_check(d, 8, 1'b0);
			rx_run(1'b1);
		join
		check_rx();
		report_and_stop();
	end
endmodule
`default_nettype wire
